// [pkg/irq_route_pkg.sv]
// Package with indices, reset values and carrier types for interrupt and DMA routing.
package irq_route_pkg;

	// Configuration port defaults and relocation range.
	localparam logic [15:0] CFG_PORT_STRAP_LOW  = 16'h002E;
	localparam logic [15:0] CFG_PORT_STRAP_HIGH = 16'h004E;
	localparam logic [15:0] CFG_PORT_MIN        = 16'h0100;
	localparam logic [15:0] CFG_PORT_MAX        = 16'h0FFE;

	// Global configuration register indices.
	localparam logic [7:0] IDX_LDEV_SELECT    = 8'h07;
	localparam logic [7:0] IDX_GLOBAL_OSC     = 8'h24;
	localparam logic [7:0] IDX_CFG_PORT_LOW   = 8'h26;
	localparam logic [7:0] IDX_CFG_PORT_HIGH  = 8'h27;
	localparam int         OSC_QUALIFY_BIT    = 6;

	// Per logical device register indices.
	localparam logic [7:0] IDX_ACTIVATE       = 8'h30;
	localparam logic [7:0] IDX_BASE_HIGH      = 8'h60;
	localparam logic [7:0] IDX_BASE_LOW       = 8'h61;
	localparam logic [7:0] IDX_IRQ_SELECT     = 8'h70;
	localparam logic [7:0] IDX_DMA_SELECT     = 8'h74;

	// Logical device numbers that own routing state.
	localparam logic [3:0] LDEV_FLOPPY  = 4'h0;
	localparam logic [3:0] LDEV_PRINTER = 4'h3;
	localparam logic [3:0] LDEV_UART1   = 4'h4;
	localparam logic [3:0] LDEV_UART2   = 4'h5;
	localparam int         NUM_LDEV     = 4;

	// Reset values of select registers.
	localparam logic [3:0] IRQ_SEL_RESET        = 4'h0;
	localparam logic [3:0] IRQ_SEL_FLOPPY_RESET = 4'h6;
	localparam logic [2:0] DMA_SEL_FLOPPY_RESET = 3'h2;
	localparam logic [2:0] DMA_SEL_OTHER_RESET  = 3'h4;
	localparam logic [3:0] IRQ_SMI_SHARED       = 4'h2;
	localparam logic [15:0] BASE_RESET          = 16'h0000;

	// Printer port modes whose interrupt is forced enabled.
	localparam logic [2:0] PP_MODE_FIFO = 3'b010;
	localparam logic [2:0] PP_MODE_ECP  = 3'b011;
	localparam logic [2:0] PP_MODE_TEST = 3'b110;

	// Configuration bus access states.
	typedef enum logic [1:0] {
		CFG_LOCKED = 2'b00,
		CFG_OPEN   = 2'b01
	} cfg_state_t;

	// Host configuration cycle from the bus front end.
	typedef struct packed {
		logic        write;
		logic        read;
		logic [15:0] addr;
		logic [7:0]  data;
	} io_cycle_t;

	// Gate bits owned by the functions themselves.
	typedef struct packed {
		logic       floppyDmaGate;
		logic       floppyPowerDown;
		logic       floppyIrqReq;
		logic       floppyDmaReq;
		logic       parallelIrqGate;
		logic       ecpServiceMask;
		logic       ecpDmaGate;
		logic [2:0] printerMode;
		logic       printerIrqReq;
		logic       printerDmaReq;
		logic [3:0] uart1IntEnable;
		logic       uart1AuxOutTwo;
		logic       uart1IrqReq;
		logic [3:0] uart2IntEnable;
		logic       uart2AuxOutTwo;
		logic       uart2IrqReq;
	} func_gates_t;

	// Per logical device routing state.
	typedef struct packed {
		logic        active;
		logic [15:0] base;
		logic [3:0]  irqSel;
		logic [2:0]  dmaSel;
	} ldev_cfg_t;

endpackage : irq_route_pkg

// [design/line_router.sv]
// One logical device's gated request onto a one-hot set of physical lines.
`timescale 1ns/1ps
`default_nettype none
module line_router
	import irq_route_pkg::*;
#(
	parameter int SEL_W   = 4,
	parameter int LINES   = 16,
	parameter int MAX_SEL = 15
) (
	// Selection and request.
	input  wire logic [SEL_W-1:0] sel,
	input  wire logic             enable,
	input  wire logic             request,
	// Routed lines, bit n for line n.
	output logic      [LINES-1:0] lineReq,
	output logic      [LINES-1:0] lineUsed
);

	// Decode a non-zero, in-range selection; zero and higher codes route nowhere.
	always_comb begin
		lineReq  = '0;
		lineUsed = '0;
		for (int n = 1; n < LINES; n++) begin
			if (int'(sel) == n && n <= MAX_SEL) begin
				lineUsed[n] = enable;
				lineReq[n]  = enable & request;
			end
		end
	end

endmodule : line_router
`default_nettype wire

// [design/ldev_irq_dma_routing.sv]
// Configuration port and per logical device interrupt and DMA routing.
//
// Function
// - Relocated config port base is even in 0x0100..0x0FFE; index at base, data at base+1.
// - Device bases decode A11..A3; oscillator bit 6 also demands A15..A12 zero.
// - Port starts at 0x02E or 0x04E by strap; relocatable via indices 0x26, 0x27.
// - Interrupt select bits 3:0: zero none, 1..15 pick IRQ1..IRQ15, 2 shared.
// - Interrupt selects reset to zero, floppy resets to 0x06.
// - Routed interrupts are active high; system management interrupt is active low.
// - Interrupt needs non-zero select and function enable; floppy uses its DMA gate.
// - Printer interrupt needs its gate or a forced mode; extended mode also needs service mask clear.
// - Serial interrupt needs an enable bit D0..D3 and auxiliary output two set.
// - Lines selected by no device stay disabled and undriven.
// - DMA select bits 2:0: 0 reserved, 1..3 channels, 4..7 none.
// - DMA select resets to 0x02 for floppy, 0x04 for printer and serial two.
// - DMA active only for select 1..3 and the function's DMA gate set.
// - DMA channels selected by no device stay disabled.
// - A function disabling its own request also disables the routed line.
// - Floppy interrupt and DMA off when its gate is zero or powered down.
// - Printer modes 010, 011, 110 force interrupt on; DMA follows the DMA gate.
// - Device active on activate or power bit; the two bits are linked.
`timescale 1ns/1ps
`default_nettype none
module ldev_irq_dma_routing
	import irq_route_pkg::*;
#(
	parameter int IRQ_LINES = 16,
	parameter int DMA_LINES = 4
) (
	// Clock and reset.
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic                 softReset,
	// Power-up strap selecting the default configuration port.
	input  wire logic                 config_port_strap,
	// Host I/O cycles and read data.
	input  wire io_cycle_t            ioCycle,
	output logic      [7:0]           ioReadData,
	output logic                      ioReadHit,
	// Function gate bits and raw requests.
	input  wire func_gates_t          gates,
	input  wire logic                 powerControl [NUM_LDEV],
	input  wire logic                 smiEnable,
	input  wire logic                 smiRequest,
	// Routed physical lines with their drive enables.
	output logic      [IRQ_LINES-1:0] irqLine,
	output logic      [IRQ_LINES-1:0] irqLineOe,
	output logic      [DMA_LINES-1:0] dmaReqLine,
	output logic      [DMA_LINES-1:0] dmaLineOe,
	output logic                      system_mgmt_irq_n,
	// Decoded device base hits for the function blocks.
	output logic      [NUM_LDEV-1:0]  baseHit
);

	// Configuration state.
	cfg_state_t  cfgState;
	cfg_state_t  next_cfgState;
	logic        strapTaken;
	logic        next_strapTaken;
	logic [15:0] cfgPort;
	logic [15:0] next_cfgPort;
	logic [7:0]  cfgIndex;
	logic [7:0]  next_cfgIndex;
	logic [3:0]  ldevSel;
	logic [3:0]  next_ldevSel;
	logic [7:0]  globalOsc;
	logic [7:0]  next_globalOsc;
	ldev_cfg_t   ldev      [NUM_LDEV];
	ldev_cfg_t   next_ldev [NUM_LDEV];
	logic [7:0]  next_ioReadData;
	logic        next_ioReadHit;

	// Which table slot the selected logical device occupies, or none.
	logic        slotValid;
	logic [1:0]  slot;

	// Map logical device numbers to the four routed slots.
	always_comb begin
		slotValid = 1'b1;
		slot      = 2'd0;
		if (ldevSel == LDEV_FLOPPY) begin
			slot = 2'd0;
		end else if (ldevSel == LDEV_PRINTER) begin
			slot = 2'd1;
		end else if (ldevSel == LDEV_UART1) begin
			slot = 2'd2;
		end else if (ldevSel == LDEV_UART2) begin
			slot = 2'd3;
		end else begin
			slotValid = 1'b0;
		end
	end

	// Port hits; the base is even, so index and data share all but bit 0.
	logic idxHit;
	logic dataHit;
	assign idxHit  = (ioCycle.addr == cfgPort);
	assign dataHit = (ioCycle.addr == (cfgPort | 16'h0001));

	// Reset value for one slot; used by the hard reset only.
	function automatic ldev_cfg_t slot_reset(input int s);
		ldev_cfg_t r;
		r.active = 1'b0;
		r.base   = BASE_RESET;
		r.irqSel = (s == 0) ? IRQ_SEL_FLOPPY_RESET : IRQ_SEL_RESET;
		r.dmaSel = (s == 0) ? DMA_SEL_FLOPPY_RESET : DMA_SEL_OTHER_RESET;
		return r;
	endfunction : slot_reset

	// Next configuration state from host cycles and soft reset.
	always_comb begin
		logic [15:0] cand;
		cand            = cfgPort;
		next_cfgState   = cfgState;
		next_strapTaken = 1'b1;
		next_cfgPort    = cfgPort;
		next_cfgIndex   = cfgIndex;
		next_ldevSel    = ldevSel;
		next_globalOsc  = globalOsc;
		next_ioReadData = ioReadData;
		next_ioReadHit  = 1'b0;
		for (int s = 0; s < NUM_LDEV; s++) begin
			next_ldev[s] = ldev[s];
		end
		// The strap is caught once after reset release, never inside reset.
		if (!strapTaken) begin
			next_cfgPort = config_port_strap ? CFG_PORT_STRAP_HIGH : CFG_PORT_STRAP_LOW;
		end
		next_cfgState = CFG_OPEN;
		if (ioCycle.write && idxHit) begin
			next_cfgIndex = ioCycle.data;
		end else if (ioCycle.write && dataHit) begin
			if (cfgIndex == IDX_LDEV_SELECT) begin
				next_ldevSel = ioCycle.data[3:0];
			end else if (cfgIndex == IDX_GLOBAL_OSC) begin
				next_globalOsc = ioCycle.data;
			end else if (cfgIndex == IDX_CFG_PORT_LOW) begin
				cand = {cfgPort[15:8], ioCycle.data};
				// An odd or out-of-range base would split index and data; it is refused.
				if (!cand[0] && cand >= CFG_PORT_MIN && cand <= CFG_PORT_MAX) begin
					next_cfgPort = cand;
				end
			end else if (cfgIndex == IDX_CFG_PORT_HIGH) begin
				cand = {ioCycle.data, cfgPort[7:0]};
				if (!cand[0] && cand >= CFG_PORT_MIN && cand <= CFG_PORT_MAX) begin
					next_cfgPort = cand;
				end
			end else if (slotValid && cfgIndex == IDX_ACTIVATE) begin
				next_ldev[slot].active = ioCycle.data[0];
			end else if (slotValid && cfgIndex == IDX_BASE_HIGH) begin
				next_ldev[slot].base[15:8] = ioCycle.data;
			end else if (slotValid && cfgIndex == IDX_BASE_LOW) begin
				next_ldev[slot].base[7:0] = ioCycle.data;
			end else if (slotValid && cfgIndex == IDX_IRQ_SELECT) begin
				next_ldev[slot].irqSel = ioCycle.data[3:0];
			end else if (slotValid && cfgIndex == IDX_DMA_SELECT) begin
				next_ldev[slot].dmaSel = ioCycle.data[2:0];
			end
		end else if (ioCycle.read && idxHit) begin
			next_ioReadData = cfgIndex;
			next_ioReadHit  = 1'b1;
		end else if (ioCycle.read && dataHit) begin
			next_ioReadHit  = 1'b1;
			next_ioReadData = 8'h00;
			if (cfgIndex == IDX_LDEV_SELECT) begin
				next_ioReadData = {4'h0, ldevSel};
			end else if (cfgIndex == IDX_GLOBAL_OSC) begin
				next_ioReadData = globalOsc;
			end else if (cfgIndex == IDX_CFG_PORT_LOW) begin
				next_ioReadData = cfgPort[7:0];
			end else if (cfgIndex == IDX_CFG_PORT_HIGH) begin
				next_ioReadData = cfgPort[15:8];
			end else if (slotValid && cfgIndex == IDX_ACTIVATE) begin
				next_ioReadData = {7'h00, ldev[slot].active | powerControl[slot]};
			end else if (slotValid && cfgIndex == IDX_BASE_HIGH) begin
				next_ioReadData = ldev[slot].base[15:8];
			end else if (slotValid && cfgIndex == IDX_BASE_LOW) begin
				next_ioReadData = ldev[slot].base[7:0];
			end else if (slotValid && cfgIndex == IDX_IRQ_SELECT) begin
				next_ioReadData = {4'h0, ldev[slot].irqSel};
			end else if (slotValid && cfgIndex == IDX_DMA_SELECT) begin
				next_ioReadData = {5'h00, ldev[slot].dmaSel};
			end
		end
		// Soft reset returns the select registers to their defaults.
		if (softReset) begin
			for (int s = 0; s < NUM_LDEV; s++) begin
				next_ldev[s].irqSel = (s == 0) ? IRQ_SEL_FLOPPY_RESET : IRQ_SEL_RESET;
				next_ldev[s].dmaSel = (s == 0) ? DMA_SEL_FLOPPY_RESET : DMA_SEL_OTHER_RESET;
			end
		end
	end

	// Register the configuration state.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgState   <= CFG_LOCKED;
			strapTaken <= 1'b0;
			cfgPort    <= CFG_PORT_STRAP_LOW;
			cfgIndex   <= 8'h00;
			ldevSel    <= 4'h0;
			globalOsc  <= 8'h00;
			ioReadData <= 8'h00;
			ioReadHit  <= 1'b0;
			for (int s = 0; s < NUM_LDEV; s++) begin
				ldev[s] <= slot_reset(s);
			end
		end else begin
			cfgState   <= next_cfgState;
			strapTaken <= next_strapTaken;
			cfgPort    <= next_cfgPort;
			cfgIndex   <= next_cfgIndex;
			ldevSel    <= next_ldevSel;
			globalOsc  <= next_globalOsc;
			ioReadData <= next_ioReadData;
			ioReadHit  <= next_ioReadHit;
			for (int s = 0; s < NUM_LDEV; s++) begin
				ldev[s] <= next_ldev[s];
			end
		end
	end

	// Device activity and base validity; an invalid base disables the routing too.
	logic [NUM_LDEV-1:0] devOn;
	logic [NUM_LDEV-1:0] baseValid;
	always_comb begin
		for (int s = 0; s < NUM_LDEV; s++) begin
			devOn[s]     = ldev[s].active | powerControl[s];
			baseValid[s] = (ldev[s].base[11:0] >= CFG_PORT_MIN[11:0]);
			baseHit[s]   = devOn[s] && baseValid[s]
				&& (ioCycle.addr[11:3] == ldev[s].base[11:3])
				&& (!globalOsc[OSC_QUALIFY_BIT] || ioCycle.addr[15:12] == 4'h0);
		end
	end

	// Function gates for interrupts and DMA per slot.
	logic [NUM_LDEV-1:0] irqEnable;
	logic [NUM_LDEV-1:0] irqRequest;
	logic [NUM_LDEV-1:0] dmaEnable;
	logic [NUM_LDEV-1:0] dmaRequest;
	logic                ppForced;
	logic                ppIrqGate;
	logic                floppyGate;
	always_comb begin
		floppyGate = gates.floppyDmaGate && !gates.floppyPowerDown;
		ppForced   = (gates.printerMode == PP_MODE_FIFO) || (gates.printerMode == PP_MODE_ECP)
			|| (gates.printerMode == PP_MODE_TEST);
		// In extended mode a pending service request masks the interrupt.
		ppIrqGate  = (ppForced || gates.parallelIrqGate)
			&& !((gates.printerMode == PP_MODE_ECP) && gates.ecpServiceMask);
		irqEnable[0]  = floppyGate;
		irqEnable[1]  = ppIrqGate;
		irqEnable[2]  = (|gates.uart1IntEnable) && gates.uart1AuxOutTwo;
		irqEnable[3]  = (|gates.uart2IntEnable) && gates.uart2AuxOutTwo;
		irqRequest[0] = gates.floppyIrqReq;
		irqRequest[1] = gates.printerIrqReq;
		irqRequest[2] = gates.uart1IrqReq;
		irqRequest[3] = gates.uart2IrqReq;
		dmaEnable[0]  = floppyGate;
		dmaEnable[1]  = gates.ecpDmaGate;
		dmaEnable[2]  = 1'b0;
		dmaEnable[3]  = 1'b0;
		dmaRequest[0] = gates.floppyDmaReq;
		dmaRequest[1] = gates.printerDmaReq;
		dmaRequest[2] = 1'b0;
		dmaRequest[3] = 1'b0;
	end

	// One router per slot for interrupts and for DMA.
	logic [IRQ_LINES-1:0] irqReqSlot [NUM_LDEV];
	logic [IRQ_LINES-1:0] irqUseSlot [NUM_LDEV];
	logic [DMA_LINES-1:0] dmaReqSlot [NUM_LDEV];
	logic [DMA_LINES-1:0] dmaUseSlot [NUM_LDEV];
	for (genvar s = 0; s < NUM_LDEV; s++) begin : gRoute
		line_router #(.SEL_W(4), .LINES(IRQ_LINES), .MAX_SEL(15)) uIrq (
			.sel      (ldev[s].irqSel),
			.enable   (devOn[s] && baseValid[s] && irqEnable[s]),
			.request  (irqRequest[s]),
			.lineReq  (irqReqSlot[s]),
			.lineUsed (irqUseSlot[s])
		);
		// Codes 4..7 lie beyond the channel count and route nowhere.
		line_router #(.SEL_W(3), .LINES(DMA_LINES), .MAX_SEL(3)) uDma (
			.sel      (ldev[s].dmaSel),
			.enable   (devOn[s] && baseValid[s] && dmaEnable[s]),
			.request  (dmaRequest[s]),
			.lineReq  (dmaReqSlot[s]),
			.lineUsed (dmaUseSlot[s])
		);
	end

	// OR the slot requests per line; lines nobody selects stay undriven.
	always_comb begin
		irqLine    = '0;
		irqLineOe  = '0;
		dmaReqLine = '0;
		dmaLineOe  = '0;
		for (int s = 0; s < NUM_LDEV; s++) begin
			irqLine    = irqLine | irqReqSlot[s];
			irqLineOe  = irqLineOe | irqUseSlot[s];
			dmaReqLine = dmaReqLine | dmaReqSlot[s];
			dmaLineOe  = dmaLineOe | dmaUseSlot[s];
		end
		// The management interrupt shares line two; software must turn it off first.
		system_mgmt_irq_n = !(smiEnable && smiRequest);
	end

endmodule : ldev_irq_dma_routing
`default_nettype wire

// [test/ldev_irq_dma_routing_assertions.sv]
// Checker for routing, read answers and the management interrupt at the top ports.
`timescale 1ns/1ps
`default_nettype none
module ldev_irq_dma_routing_checker
	import irq_route_pkg::*;
#(
	parameter int IRQ_LINES = 16,
	parameter int DMA_LINES = 4
) (
	// Clock and reset.
	input wire logic                 ref_clk,
	input wire logic                 rst_n,
	// Host cycles and answers.
	input wire io_cycle_t            ioCycle,
	input wire logic [7:0]           ioReadData,
	input wire logic                 ioReadHit,
	// Function gates and management request.
	input wire func_gates_t          gates,
	input wire logic                 smiEnable,
	input wire logic                 smiRequest,
	// Routed lines.
	input wire logic [IRQ_LINES-1:0] irqLine,
	input wire logic [IRQ_LINES-1:0] irqLineOe,
	input wire logic [DMA_LINES-1:0] dmaReqLine,
	input wire logic [DMA_LINES-1:0] dmaLineOe,
	input wire logic                 system_mgmt_irq_n
);
	// All checks share the block clock and sleep under reset.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// A line without an owner must never carry a request.
	unused_irq_a: assert property ((irqLine & ~irqLineOe) == '0)
		else $error("irq request on unowned line");
	unused_dma_a: assert property ((dmaReqLine & ~dmaLineOe) == '0)
		else $error("dma request on unowned channel");
	dma_reserved_a: assert property (!dmaLineOe[0] && !dmaReqLine[0])
		else $error("reserved dma channel driven");
	irq_none_a: assert property (!irqLineOe[0] && !irqLine[0])
		else $error("select zero drove a line");
	// With both dma gates shut, or the floppy asleep and the ecp gate shut, no channel may open.
	dma_gate_a: assert property (!gates.floppyDmaGate && !gates.ecpDmaGate |-> dmaLineOe == '0)
		else $error("dma channel open without gate");
	fdc_off_a: assert property (gates.floppyPowerDown && !gates.ecpDmaGate |-> dmaLineOe == '0)
		else $error("dma open while floppy powered down");
	// Answers only follow a read one cycle earlier, and data holds otherwise.
	read_answer_a: assert property (ioReadHit |-> $past(ioCycle.read))
		else $error("read answer without read cycle");
	read_hold_a: assert property (!$past(ioCycle.read) |-> $stable(ioReadData))
		else $error("read data moved without read");
	smi_low_a: assert property (system_mgmt_irq_n == !(smiEnable && smiRequest))
		else $error("management interrupt level wrong");
	reset_quiet_a: assert property ($rose(rst_n) |-> irqLineOe == '0 && dmaLineOe == '0)
		else $error("lines enabled straight after reset");
	no_request_a: assert property (!gates.floppyDmaReq && !gates.printerDmaReq |-> dmaReqLine == '0)
		else $error("dma line set without any request");

	// Main scenarios reached.
	cover property (ioReadHit);
	cover property (irqLine != '0);
	cover property (dmaReqLine != '0);
endmodule : ldev_irq_dma_routing_checker

bind ldev_irq_dma_routing ldev_irq_dma_routing_checker #(
	.IRQ_LINES(IRQ_LINES),
	.DMA_LINES(DMA_LINES)
) chk (
	.ref_clk, .rst_n, .ioCycle, .ioReadData, .ioReadHit, .gates, .smiEnable, .smiRequest,
	.irqLine, .irqLineOe, .dmaReqLine, .dmaLineOe, .system_mgmt_irq_n
);
`default_nettype wire

// [test/lpc_host_model.sv]
// Host model issuing configuration cycles through the index and data ports.
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model
	import irq_route_pkg::*;
(
	// Clock.
	input  wire logic       ref_clk,
	// Cycles out, answers back.
	output var io_cycle_t   ioCycle,
	input  wire logic [7:0] ioReadData,
	input  wire logic       ioReadHit
);
	logic [15:0] port = CFG_PORT_STRAP_LOW;
	logic [7:0]  got;
	logic        hit;

	// Bus starts idle.
	initial ioCycle = '0;

	// One cycle; address and data are inverted when released so stale values never match.
	task automatic io(input logic w, r, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		ioCycle <= '{w, r, a, d};
		@(posedge ref_clk);
		ioCycle <= '{1'b0, 1'b0, ~a, ~d};
		#1;
		got = ioReadData;
		hit = ioReadHit;
	endtask : io

	// Index goes to the port, data to the port plus one.
	task automatic cfg_wr(input logic [7:0] i, v);
		io(1'b1, 1'b0, port, i);
		io(1'b1, 1'b0, port + 16'h0001, v);
	endtask : cfg_wr

	task automatic cfg_rd(input logic [7:0] i);
		io(1'b1, 1'b0, port, i);
		io(1'b0, 1'b1, port + 16'h0001, 8'h00);
	endtask : cfg_rd
endmodule : lpc_host_model
`default_nettype wire

// [test/ldev_irq_dma_routing_test.sv]
// Self-checking bench for the interrupt and DMA routing block.
`timescale 1ns/1ps
`default_nettype none
module ldev_irq_dma_routing_test
	import irq_route_pkg::*;
;
	// Gating case: printer mode and gates, uart enables, floppy bits, then expectations.
	typedef struct packed {
		logic [2:0] mode;
		logic       ig, sm, dg;
		logic [3:0] ue;
		logic       ax, fg, fp, eP, eU, eF;
	} row_t;
	localparam row_t ROWS [10] = '{16'h0073, 16'h3424, 16'h409C, 16'h6537, 16'h7A22,
		16'h83C0, 16'hBC35, 16'hC82C, 16'hE062, 16'hF03C};
	localparam logic [7:0] DV [4] = '{8'h00, 8'h03, 8'h04, 8'h05};
	localparam logic [7:0] BH [4] = '{8'h03, 8'h03, 8'h03, 8'h02};
	localparam logic [7:0] BL [4] = '{8'hF0, 8'h78, 8'hF8, 8'hF8};
	localparam logic [7:0] IQ [4] = '{8'h06, 8'h07, 8'h04, 8'h03};

	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        softReset = 1'b0;
	logic        config_port_strap = 1'b0;
	io_cycle_t   ioCycle;
	logic [7:0]  ioReadData;
	logic        ioReadHit;
	func_gates_t gates = '0;
	logic        powerControl [NUM_LDEV] = '{default: 1'b0};
	logic        smiEnable = 1'b1;
	logic        smiRequest = 1'b0;
	logic [15:0] irqLine, irqLineOe;
	logic [3:0]  dmaReqLine, dmaLineOe, baseHit;
	logic        system_mgmt_irq_n;
	int          n_mismatch = 0;
	int          num_checks = 0;
	row_t        r;
	logic [15:0] e;

	// Free-running 20 MHz clock.
	always #25 ref_clk = ~ref_clk;

	ldev_irq_dma_routing #(.IRQ_LINES(16), .DMA_LINES(4)) dut (.ref_clk, .rst_n, .softReset,
		.config_port_strap, .ioCycle, .ioReadData, .ioReadHit, .gates, .powerControl,
		.smiEnable, .smiRequest, .irqLine, .irqLineOe, .dmaReqLine, .dmaLineOe,
		.system_mgmt_irq_n, .baseHit);
	lpc_host_model host (.ref_clk, .ioCycle, .ioReadData, .ioReadHit);

	task automatic close_out();
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic check(input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : check

	task automatic settle();
		@(posedge ref_clk);
		#1;
	endtask : settle

	task automatic ld(input logic [7:0] d, i, v);
		host.cfg_wr(8'h07, d);
		host.cfg_wr(i, v);
		settle();
	endtask : ld

	task automatic rd(input logic [7:0] d, i, v);
		host.cfg_wr(8'h07, d);
		host.cfg_rd(i);
		check({host.hit, host.got}, {1'b1, v});
	endtask : rd

	// Base decode is sampled while the host holds the address on the bus.
	task automatic hitat(input logic [15:0] a, input logic [3:0] x);
		fork
			host.io(1'b0, 1'b0, a, 8'h00);
			begin
				settle();
				check(baseHit, x);
			end
		join
	endtask : hitat

	// Every request raised; the row decides the gates.
	function automatic func_gates_t mk(row_t g);
		return {g.fg, g.fp, 2'b11, g.ig, g.sm, g.dg, g.mode, 2'b11, g.ue, g.ax, 1'b1, g.ue,
			g.ax, 1'b1};
	endfunction : mk

	// Hang guard, far beyond the few hundred cycles the run needs.
	initial begin
		#1000000;
		n_mismatch++;
		close_out();
	end

	// Main sequence.
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			ld(DV[k], 8'h60, BH[k]);
			ld(DV[k], 8'h61, BL[k]);
			ld(DV[k], 8'h70, IQ[k]);
			ld(DV[k], 8'h30, 8'h01);
		end
		ld(8'h03, 8'h74, 8'h03);
		foreach (ROWS[n]) begin
			r = ROWS[n];
			@(posedge ref_clk);
			gates <= mk(r);
			settle();
			e = '0;
			e[7] = r.eP;
			e[6] = r.eF;
			e[4] = r.eU;
			e[3] = r.eU;
			check(irqLineOe, e);
			check(irqLine, e);
			check(dmaLineOe, {r.dg, r.eF, 2'b00});
			check(dmaReqLine, {r.dg, r.eF, 2'b00});
		end
		// Printer alone in a forced mode walks every code.
		@(posedge ref_clk);
		gates <= mk(16'h6400);
		smiEnable <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			ld(8'h03, 8'h74, i[7:0]);
			check(dmaLineOe, (i > 0 && i < 4) ? 16'h0001 << i : 16'h0000);
		end
		for (int i = 0; i < 16; i++) begin
			ld(8'h03, 8'h70, i[7:0]);
			check(irqLineOe, (i == 0) ? 16'h0000 : 16'h0001 << i);
		end
		@(posedge ref_clk);
		smiEnable <= 1'b1;
		smiRequest <= 1'b1;
		settle();
		check(system_mgmt_irq_n, 16'h0000);
		@(posedge ref_clk);
		powerControl[1] <= 1'b1;
		ld(8'h03, 8'h30, 8'h00);
		rd(8'h03, 8'h30, 8'h01);
		check(irqLineOe, 16'h8000);
		@(posedge ref_clk);
		powerControl[1] <= 1'b0;
		settle();
		check(irqLineOe, 16'h0000);
		hitat(16'h53F2, 4'h1);
		host.cfg_wr(8'h24, 8'h40);
		hitat(16'h53F2, 4'h0);
		hitat(16'h03F2, 4'h1);
		rd(8'h03, 8'h71, 8'h00);
		ld(8'h03, 8'h75, 8'hAA);
		rd(8'h03, 8'h75, 8'h00);
		@(posedge ref_clk);
		softReset <= 1'b1;
		@(posedge ref_clk);
		softReset <= 1'b0;
		rd(8'h03, 8'h70, 8'h00);
		rd(8'h00, 8'h74, 8'h02);
		// Move the port; odd and out-of-range moves must be refused.
		host.cfg_wr(8'h27, 8'h02);
		host.port = 16'h022E;
		host.cfg_wr(8'h26, 8'h51);
		host.cfg_wr(8'h27, 8'h10);
		rd(8'h03, 8'h74, 8'h04);
		host.port = 16'h002E;
		host.cfg_rd(8'h70);
		check(host.hit, 16'h0000);
		// Hard reset with the strap high brings the port up at its other home.
		@(posedge ref_clk);
		rst_n <= 1'b0;
		config_port_strap <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		host.port = 16'h004E;
		for (int k = 0; k < 4; k++)
			rd(DV[k], 8'h70, (k == 0) ? 8'h06 : 8'h00);
		rd(8'h00, 8'h74, 8'h02);
		rd(8'h03, 8'h74, 8'h04);
		rd(8'h05, 8'h74, 8'h04);
		close_out();
	end
endmodule : ldev_irq_dma_routing_test
`default_nettype wire
